// ==== tap_map.svh ====
// Offsets, codes, field positions and reset values of the boundary-scan port.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// ----------------------------------------
// Scan register lengths
// ----------------------------------------
`define IR_LEN        8
`define BS_LEN        113
`define ID_LEN        32

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define IR_EXTEST     8'h00
`define IR_IDCODE     8'h21
`define IR_SAMPLE     8'h05
`define IR_CLAMP      8'h07
`define IR_HIGHZ      8'h03
`define IR_BYPASS     8'hff
`define IR_CAPTURE    8'h01

// ----------------------------------------
// Identification word fields
// ----------------------------------------
`define ID_PRESENT    1'b1

// ----------------------------------------
// Register port map and reset values
// ----------------------------------------
`define REG_CTRL      4'h0
`define REG_STAT      4'h4
`define CTRL_RST      1'b1
`define STAT_IR_LSB   0
`define STAT_DRIVE    8
`define STAT_FLOAT    9

`endif

// ==== tap_pkg.sv ====
// Types shared by the boundary-scan port: controller states and carriers.
// Assumes tap_map.svh sits in the same folder.
package tap_pkg;
	`include "tap_map.svh"

	// ----------------------------------------
	// Controller states, one-hot
	// ----------------------------------------
	typedef enum logic [15:0] {
		st_tlr    = 16'h0001,
		st_rti    = 16'h0002,
		st_sel_dr = 16'h0004,
		st_cap_dr = 16'h0008,
		st_sh_dr  = 16'h0010,
		st_ex1_dr = 16'h0020,
		st_pa_dr  = 16'h0040,
		st_ex2_dr = 16'h0080,
		st_up_dr  = 16'h0100,
		st_sel_ir = 16'h0200,
		st_cap_ir = 16'h0400,
		st_sh_ir  = 16'h0800,
		st_ex1_ir = 16'h1000,
		st_pa_ir  = 16'h2000,
		st_ex2_ir = 16'h4000,
		st_up_ir  = 16'h8000
	} tap_state_type;

	// ----------------------------------------
	// Ball drive carrier: value and enable per cell
	// ----------------------------------------
	typedef struct packed {
		logic [`BS_LEN-1:0] value;
		logic [`BS_LEN-1:0] enable;
	} ball_bus_type;

	// Test-clock side state
	typedef struct packed {
		tap_state_type      st;
		logic [`IR_LEN-1:0] ir;
		logic [`IR_LEN-1:0] ir_sh;
		logic [`BS_LEN-1:0] bs_sh;
		logic [`BS_LEN-1:0] bs_upd;
		logic [`ID_LEN-1:0] id_sh;
		logic               byp;
		logic               test_drive;
		logic               test_float;
		logic               upd_tgl;
		logic [`BS_LEN-1:0] in_s1;
		logic [`BS_LEN-1:0] in_s2;
	} tck_state_type;

	// Falling-edge output state
	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} tdo_state_type;

	// System-clock side state
	typedef struct packed {
		logic               tgl_s1;
		logic               tgl_s2;
		logic               tgl_seen;
		logic               drive_s1;
		logic               drive_s2;
		logic               float_s1;
		logic               float_s2;
		logic [`BS_LEN-1:0] upd_cap;
		logic [`IR_LEN-1:0] ir_cap;
		logic               core_en;
		logic [31:0]        rdata;
		ball_bus_type       balls;
	} sys_state_type;
endpackage

// ==== memory_boundary_scan_tap.sv ====
// Boundary-scan test access port of the memory: controller, instruction,
// identification, bypass and boundary registers, plus ball drive override.
// Assumes tck from the tester, ball_in and core_drive in the sys_clk domain.
//
// What this block does
// - Code 00h selects boundary chain, captures ring; balls driven from boundary update values.
// - Code 21h loads identification word and selects it for shifting.
// - Code 05h captures pin ring into boundary chain and selects it.
// - Code 07h selects bypass; balls driven from boundary update values.
// - Code 03h selects bypass and floats every ball driver.
// - Code FFh selects bypass with no effect on memory operation.
// - Identification bits 31:28 carry die revision and width organisation.
// - Identification bits 27:12 carry the sixteen-bit device field.
// - Identification bits 11:1 carry the fixed maker code.
// - Identification bit 0 is always one.
// - Chain order starts at write clock pair; data balls take two cells.
// - Eight-bit instruction takes effect only at Update-IR.
// - Reset state loads the identification instruction.
// - Sample snapshot of input balls is taken in Capture-DR.
// - Extest enables drivers at Update-IR with preloaded chain data.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "tap_map.svh"

module memory_boundary_scan_tap #(
	parameter logic [1:0]  DIE_REV    = 2'h0,
	parameter logic [1:0]  WIDTH_ORG  = 2'h0,
	parameter logic [15:0] DEVICE_FLD = 16'h1234, // Arbitrary value
	parameter logic [10:0] MAKER_CODE = 11'h2a5   // Arbitrary value
) (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe,
	input  wire logic [`BS_LEN-1:0]   ball_in,
	input  wire tap_pkg::ball_bus_type core_drive,
	output tap_pkg::ball_bus_type     ball_drive,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata
);
	import tap_pkg::*;

	// ----------------------------------------
	// Test-clock reset release
	// ----------------------------------------
	logic          trst_s1_n;
	logic          tck_rst_n;
	tck_state_type t_r;
	tck_state_type t_nxt;
	tdo_state_type o_r;
	tdo_state_type o_nxt;
	sys_state_type s_r;
	sys_state_type s_nxt;
	logic          sel_bs;
	logic          sel_id;
	logic [`ID_LEN-1:0] id_word;

	// Async assert, tck-synchronous release so the controller starts cleanly
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			trst_s1_n <= 1'b0;
			tck_rst_n <= 1'b0;
		end else begin
			trst_s1_n <= 1'b1;
			tck_rst_n <= trst_s1_n;
		end
	end

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	// Reserved codes fall to bypass, the safe one-bit path
	assign sel_bs  = (t_r.ir == `IR_EXTEST) || (t_r.ir == `IR_SAMPLE);
	assign sel_id  = (t_r.ir == `IR_IDCODE);
	assign id_word = {DIE_REV, WIDTH_ORG, DEVICE_FLD, MAKER_CODE, `ID_PRESENT};

	// ----------------------------------------
	// Test-clock logic
	// ----------------------------------------
	// Controller walk, scan capture, shift and update
	always_comb begin
		t_nxt       = t_r;
		t_nxt.in_s1 = ball_in;
		t_nxt.in_s2 = t_r.in_s1;
		unique case (t_r.st)
			st_tlr:    t_nxt.st = tms ? st_tlr : st_rti;
			st_rti:    t_nxt.st = tms ? st_sel_dr : st_rti;
			st_sel_dr: t_nxt.st = tms ? st_sel_ir : st_cap_dr;
			st_cap_dr: t_nxt.st = tms ? st_ex1_dr : st_sh_dr;
			st_sh_dr:  t_nxt.st = tms ? st_ex1_dr : st_sh_dr;
			st_ex1_dr: t_nxt.st = tms ? st_up_dr : st_pa_dr;
			st_pa_dr:  t_nxt.st = tms ? st_ex2_dr : st_pa_dr;
			st_ex2_dr: t_nxt.st = tms ? st_up_dr : st_sh_dr;
			st_up_dr:  t_nxt.st = tms ? st_sel_dr : st_rti;
			st_sel_ir: t_nxt.st = tms ? st_tlr : st_cap_ir;
			st_cap_ir: t_nxt.st = tms ? st_ex1_ir : st_sh_ir;
			st_sh_ir:  t_nxt.st = tms ? st_ex1_ir : st_sh_ir;
			st_ex1_ir: t_nxt.st = tms ? st_up_ir : st_pa_ir;
			st_pa_ir:  t_nxt.st = tms ? st_ex2_ir : st_pa_ir;
			st_ex2_ir: t_nxt.st = tms ? st_up_ir : st_sh_ir;
			st_up_ir:  t_nxt.st = tms ? st_sel_dr : st_rti;
		endcase
		unique case (t_r.st)
			st_tlr: begin
				t_nxt.ir = `IR_IDCODE;
			end
			st_cap_ir: begin
				t_nxt.ir_sh = `IR_CAPTURE;
			end
			st_sh_ir: begin
				t_nxt.ir_sh = {tdi, t_r.ir_sh[`IR_LEN-1:1]};
			end
			st_up_ir: begin
				t_nxt.ir = t_r.ir_sh;
				t_nxt.upd_tgl = ~t_r.upd_tgl;
			end
			st_cap_dr: begin
				// Input snapshot passed two tck flops; pin timing is the tester's job
				if (sel_bs)
					t_nxt.bs_sh = t_r.in_s2;
				t_nxt.id_sh = id_word;
				t_nxt.byp   = 1'b0;
			end
			st_sh_dr: begin
				// Cell 1 (write clock) leaves first at tdo
				if (sel_bs)
					t_nxt.bs_sh = {tdi, t_r.bs_sh[`BS_LEN-1:1]};
				else if (sel_id)
					t_nxt.id_sh = {tdi, t_r.id_sh[`ID_LEN-1:1]};
				else
					t_nxt.byp = tdi;
			end
			st_up_dr: begin
				if (sel_bs) begin
					t_nxt.bs_upd  = t_r.bs_sh;
					t_nxt.upd_tgl = ~t_r.upd_tgl;
				end
			end
			default: begin
			end
		endcase
		// Modes registered from the new instruction so the crossing sees clean levels
		t_nxt.test_drive = (t_nxt.ir == `IR_EXTEST) || (t_nxt.ir == `IR_CLAMP);
		t_nxt.test_float = (t_nxt.ir == `IR_HIGHZ);
	end

	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			t_r       <= '0;
			t_r.st    <= st_tlr;
			t_r.ir    <= `IR_IDCODE;
			t_r.ir_sh <= `IR_IDCODE;
		end else begin
			t_r <= t_nxt;
		end
	end

	// ----------------------------------------
	// Serial output on the falling edge
	// ----------------------------------------
	always_comb begin
		o_nxt.tdo_oe = (t_r.st == st_sh_dr) || (t_r.st == st_sh_ir);
		if (t_r.st == st_sh_ir)
			o_nxt.tdo = t_r.ir_sh[0];
		else if (sel_bs)
			o_nxt.tdo = t_r.bs_sh[0];
		else if (sel_id)
			o_nxt.tdo = t_r.id_sh[0];
		else
			o_nxt.tdo = t_r.byp;
	end

	always_ff @(negedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n)
			o_r <= '0;
		else
			o_r <= o_nxt;
	end

	assign tdo    = o_r.tdo;
	assign tdo_oe = o_r.tdo_oe;

	// ----------------------------------------
	// System-clock side: crossing, ball override, register port
	// ----------------------------------------
	// Update words are stable for many sys_clk cycles after a toggle, so
	// the synced toggle edge is a safe moment to take them over
	always_comb begin
		s_nxt          = s_r;
		s_nxt.tgl_s1   = t_r.upd_tgl;
		s_nxt.tgl_s2   = s_r.tgl_s1;
		s_nxt.tgl_seen = s_r.tgl_s2;
		s_nxt.drive_s1 = t_r.test_drive;
		s_nxt.drive_s2 = s_r.drive_s1;
		s_nxt.float_s1 = t_r.test_float;
		s_nxt.float_s2 = s_r.float_s1;
		if (s_r.tgl_s2 != s_r.tgl_seen) begin
			s_nxt.upd_cap = t_r.bs_upd;
			s_nxt.ir_cap  = t_r.ir;
		end
		// Float beats drive; otherwise the core keeps the balls
		if (s_r.float_s2) begin
			s_nxt.balls.value  = core_drive.value;
			s_nxt.balls.enable = '0;
		end else if (s_r.drive_s2) begin
			s_nxt.balls.value  = s_r.upd_cap;
			s_nxt.balls.enable = '1;
		end else begin
			s_nxt.balls.value  = core_drive.value;
			s_nxt.balls.enable = s_r.core_en ? core_drive.enable : '0;
		end
		if (reg_wr && (reg_addr == `REG_CTRL))
			s_nxt.core_en = reg_wdata[0];
		// Reads answer the cycle after the strobe; unmapped offsets give zero
		s_nxt.rdata = '0;
		if (reg_rd && (reg_addr == `REG_CTRL))
			s_nxt.rdata[0] = s_r.core_en;
		else if (reg_rd && (reg_addr == `REG_STAT)) begin
			s_nxt.rdata[`STAT_IR_LSB +: `IR_LEN] = s_r.ir_cap;
			s_nxt.rdata[`STAT_DRIVE] = s_r.drive_s2;
			s_nxt.rdata[`STAT_FLOAT] = s_r.float_s2;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_r         <= '0;
			s_r.ir_cap  <= `IR_IDCODE;
			s_r.core_en <= `CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ball_drive = s_r.balls;
	assign reg_rdata  = s_r.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Test-clock checks default to the rising tck edge
	default clocking tck_cb @(posedge tck);
	endclocking
	default disable iff (!tck_rst_n);

	chk_tlr_loads_id: assert property (t_r.st == st_tlr |=> t_r.ir == `IR_IDCODE)
		else $error("reset state did not load identification code");
	chk_ir_update_only: assert property (t_r.st != st_up_ir && t_r.st != st_tlr |=> $stable(t_r.ir))
		else $error("instruction changed outside update");
	chk_ir_update_val: assert property (t_r.st == st_up_ir |=> t_r.ir == $past(t_r.ir_sh))
		else $error("update did not take shifted instruction");
	chk_id_word_load: assert property (t_r.st == st_cap_dr && sel_id
		|=> t_r.id_sh == {DIE_REV, WIDTH_ORG, DEVICE_FLD, MAKER_CODE, 1'b1})
		else $error("identification word wrong after capture");
	chk_bs_snapshot: assert property (t_r.st == st_cap_dr && sel_bs |=> t_r.bs_sh == $past(t_r.in_s2))
		else $error("boundary snapshot not taken in capture");
	chk_bypass_capture: assert property (t_r.st == st_cap_dr && !sel_bs && !sel_id ##1 t_r.st == st_sh_dr
		|-> t_r.byp == 1'b0)
		else $error("bypass cell not cleared at capture");
	chk_extest_drive: assert property (t_r.st == st_up_ir && t_r.ir_sh == `IR_EXTEST
		|=> t_r.test_drive && !t_r.test_float)
		else $error("extest did not enable drivers");
	chk_highz_float: assert property (t_r.st == st_up_ir && t_r.ir_sh == `IR_HIGHZ
		|=> t_r.test_float && !t_r.test_drive)
		else $error("highz did not float drivers");
	chk_tms_reset: assert property (tms [*5] |=> t_r.st == st_tlr)
		else $error("five high tms did not reach reset state");
	chk_preload_upd: assert property (t_r.st == st_up_dr && sel_bs |=> t_r.bs_upd == $past(t_r.bs_sh))
		else $error("update did not latch boundary chain");
	chk_bypass_shift: assert property (t_r.st == st_sh_dr && !sel_bs && !sel_id
		|=> t_r.byp == $past(tdi))
		else $error("bypass cell did not take serial input");
	chk_ir_capture: assert property (t_r.st == st_cap_ir |=> t_r.ir_sh == `IR_CAPTURE)
		else $error("instruction capture value wrong");
	chk_tdo_enable: assert property (@(negedge tck) disable iff (!tck_rst_n)
		t_r.st == st_sh_dr || t_r.st == st_sh_ir |=> o_r.tdo_oe)
		else $error("serial output not enabled in shift");

	// System-clock checks on the ball override
	chk_float_balls: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.float_s2 |=> s_r.balls.enable == '0)
		else $error("ball enables high while floating");
	chk_clamp_value: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.drive_s2 && !s_r.float_s2 |=> s_r.balls.value == $past(s_r.upd_cap))
		else $error("balls not driven from update values");
	chk_core_pass: assert property (@(posedge sys_clk) disable iff (!resetn)
		!s_r.float_s2 && !s_r.drive_s2 && s_r.core_en |=> s_r.balls.enable == $past(core_drive.enable))
		else $error("core drive enables not passed to balls");
	chk_core_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
		!s_r.float_s2 && !s_r.drive_s2 && !s_r.core_en |=> s_r.balls.enable == '0)
		else $error("ball enables high while core gated");

	cov_id_shift: cover property (t_r.st == st_sh_dr && sel_id);
	cov_clamp_drive: cover property (@(posedge sys_clk) disable iff (!resetn) s_r.drive_s2 && !s_r.float_s2);
	cov_extest_up: cover property (t_r.st == st_up_dr && t_r.ir == `IR_EXTEST);
	cov_sample_cap: cover property (t_r.st == st_cap_dr && t_r.ir == `IR_SAMPLE);
	cov_highz_on: cover property (@(posedge sys_clk) disable iff (!resetn) s_r.float_s2);
endmodule

// ==== jtag_controller_model.sv ====
// Test controller model: drives tck, tms and tdi, and samples tdo.
// Assumes tdo moves on falling tck; tck rests low between frames.
`timescale 1ns/10ps

module jtag_controller_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// ----------------------------------------
	// Link cycles
	// ----------------------------------------
	// One 32 ns period; tdo read just before rising edge
	task automatic pulse(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#16;
		q = tdo_oe ? tdo : 1'bx; // Undriven tdo never matches
		tck = 1'b1;
		#16;
		tck = 1'b0;
	endtask

	// Non-shift cycle; tdi toggles so a stale level is never useful
	task automatic idle(input logic m);
		logic q;
		pulse(m, ~tdi, q);
	endtask

	// Five ones reach Test-Logic-Reset, then park in Run-Test/Idle
	task automatic reset_tap;
		repeat (5) idle(1'b1);
		idle(1'b0);
	endtask

	// Full IR or DR scan from Run-Test/Idle, LSB first
	task automatic scan(input logic ir_sel, input int n, input logic [112:0] din, output logic [112:0] dout);
		logic q;
		int   i;
		dout = '0;
		idle(1'b1);
		if (ir_sel) begin
			idle(1'b1);
		end
		idle(1'b0);
		idle(1'b0);
		for (i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], q);
			dout[i] = q;
		end
		idle(1'b1);
		idle(1'b0);
	endtask
endmodule

// ==== memory_boundary_scan_tap_test.sv ====
// Testbench: register tasks on sys_clk, scans through the controller model.
// Assumes tap_pkg compiled first; core pattern constant, ball pattern flips after each boundary chain scan.
`timescale 1ns/10ps

module memory_boundary_scan_tap_test;
	import tap_pkg::*;

	// Arbitrary identification values
	localparam logic [31:0]  ID_EXP = {2'h2, 2'h1, 16'h5a3c, 11'h4b1, 1'b1};
	localparam logic [112:0] B_PAT  = {1'b1, {14{8'h3c}}};
	localparam logic [112:0] P_PAT  = {1'b0, {14{8'ha6}}};
	localparam logic [112:0] C_PAT  = {1'b1, {14{8'h5a}}};
	localparam logic [112:0] E_PAT  = {1'b0, {14{8'hf0}}};

	logic          sys_clk = 1'b0;
	logic          resetn  = 1'b0;
	logic          tck, tms, tdi, tdo, tdo_oe;
	logic [112:0]  ball_in = B_PAT;
	ball_bus_type  core_drive = '{value: C_PAT, enable: E_PAT};
	ball_bus_type  ball_drive;
	logic [3:0]    reg_addr = 4'h0;
	logic [31:0]   reg_wdata = 32'h0;
	logic          reg_wr = 1'b0;
	logic          reg_rd = 1'b0;
	logic [31:0]   reg_rdata;
	int            err_total = 0;
	int            samples_checked = 0;
	logic [112:0]  dout;
	logic [31:0]   d;
	logic [7:0]    codes [7] = '{8'h05, 8'h07, 8'h03, 8'h00, 8'h21, 8'hff, 8'h05};

	always #10 sys_clk = ~sys_clk;

	memory_boundary_scan_tap #(.DIE_REV(2'h2), .WIDTH_ORG(2'h1), .DEVICE_FLD(16'h5a3c), .MAKER_CODE(11'h4b1)) u_dut (
		.sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.ball_in(ball_in), .core_drive(core_drive), .ball_drive(ball_drive), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	jtag_controller_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [112:0] got, input logic [112:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// Bounded poll until the instruction has crossed into sys_clk
	task automatic wait_ir(input logic [7:0] code, output logic [31:0] v);
		int k;
		for (k = 0; k < 30; k++) begin
			reg_read(4'h4, v);
			if (v[7:0] === code) begin
				break;
			end
		end
		if (k == 30) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, v[7:0], code);
			tally_and_finish();
		end
	endtask

	// Reset held three sys_clk cycles, which spans two rising tck edges
	task automatic do_reset;
		@(posedge sys_clk);
		resetn <= 1'b0;
		fork
			begin
				u_ctl.idle(1'b1);
				u_ctl.idle(1'b1);
			end
			begin
				repeat (3) @(posedge sys_clk);
				resetn <= 1'b1;
			end
		join
		u_ctl.reset_tap();
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		#3;
		do_reset();
		reg_read(4'h4, d);
		check(d, 32'h21);
		reg_read(4'h0, d);
		check(d, 32'h1);
		reg_read(4'h8, d);
		check(d, 32'h0);
		check(ball_drive.enable, E_PAT);
		u_ctl.scan(1'b0, 32, P_PAT, dout);
		check(dout[31:0], ID_EXP);
		$display("test reset_state done");

		// Every defined code only; sample comes back last, after two flips have restored the first ball pattern
		foreach (codes[n]) begin
			u_ctl.scan(1'b1, 8, {105'h0, codes[n]}, dout);
			check(dout[7:0], 8'h01);
			wait_ir(codes[n], d);
			check(d[9:8], {codes[n] == 8'h03, codes[n] == 8'h07 || codes[n] == 8'h00});
			repeat (8) @(posedge sys_clk);
			if (codes[n] == 8'h03) begin
				check(ball_drive.enable, '0);
			end else if (codes[n] == 8'h07 || codes[n] == 8'h00) begin
				check(ball_drive.value, P_PAT);
				check(ball_drive.enable, {113{1'b1}});
			end else begin
				check(ball_drive.value, C_PAT);
				check(ball_drive.enable, E_PAT);
			end
			if (codes[n] == 8'h00 || codes[n] == 8'h05) begin
				u_ctl.scan(1'b0, 113, P_PAT, dout);
				check(dout, ball_in);
				@(posedge sys_clk);
				ball_in <= ~ball_in;
			end else if (codes[n] == 8'h21) begin
				u_ctl.scan(1'b0, 32, P_PAT, dout);
				check(dout[31:0], ID_EXP);
			end else begin
				u_ctl.scan(1'b0, 8, {105'h0, 8'h96}, dout);
				check(dout[7:0], 8'h2c);
			end
		end
		$display("test instructions done");

		// Core gate, unmapped write ignored, then reset in mid-run
		reg_write(4'h0, 32'h0);
		reg_write(4'h8, 32'hffffffff);
		repeat (4) @(posedge sys_clk);
		check(ball_drive.enable, '0);
		reg_read(4'h0, d);
		check(d, 32'h0);
		reg_write(4'h0, 32'h1);
		repeat (4) @(posedge sys_clk);
		check(ball_drive.enable, E_PAT);
		do_reset();
		reg_read(4'h4, d);
		check(d, 32'h21);
		$display("test core_gate done");
		tally_and_finish();
	end
endmodule
